// ### design/power_stage_map.vh
// constants for the power stage fault and start-up controller
`ifndef POWER_STAGE_MAP_VH
`define POWER_STAGE_MAP_VH

// clock and timing
`define CLK_PERIOD_NS        4
`define OVERLOAD_TIME_NS     1000

// register offsets (byte addresses on the plain register port)
`define ADDR_CTRL            4'h0
`define ADDR_STATUS          4'h4
`define ADDR_LIMIT           4'h8
`define ADDR_OVLD            4'hC

// control register fields and reset value
`define CTRL_TRIM_OVR        0
`define CTRL_TRIM_SEL        1
`define CTRL_RESET_VAL       2'h0

// status register fields
`define ST_LATCH             0
`define ST_UV                1
`define ST_THERM             2
`define ST_WARN              3
`define ST_OC                4
`define ST_RESET             5
`define ST_MODE              6
`define ST_STATE_LSB         8
`define ST_STATE_MSB         12

// limit register fields
`define LIM_SAT_LSB          0
`define LIM_SAT_MSB          15
`define LIM_SUB_LSB          16
`define LIM_SUB_MSB          31

// current limits in milliamps per trim setting
`define LIM_15K_SAT          16'h1388
`define LIM_15K_SUB          16'h1F40
`define LIM_18K_SAT          16'h1194
`define LIM_18K_SUB          16'h1D4C

`endif

// ### design/flag_sync.v
// two-flop synchroniser for the analog comparator flags
`default_nettype none

module flag_sync #(
    parameter WIDTH = 1
) (
    input  wire             clock,
    input  wire             rstn,
    input  wire [WIDTH-1:0] flag_in,
    output wire [WIDTH-1:0] flag_out
);

    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    // first stage feeds only the second stage
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            meta_r <= {WIDTH{1'b0}};
            sync_r <= {WIDTH{1'b0}};
        end else begin
            meta_r <= flag_in;
            sync_r <= meta_r;
        end
    end

    assign flag_out = sync_r;

endmodule // flag_sync

`default_nettype wire

// ### design/power_stage_fault_and_startup_ctrl.v
// protection and start-up control for a six-channel power stage
// What this block does
// - a tripped current detector restrains that switch instead of shutting down
// - persistent overcurrent sets a latched overload shutdown, outputs Hi-Z
// - trim setting picks 5/8 A or 4.5/7.5 A current limits
// - warning flag drives the active-low temperature warning output low
// - thermal shutdown flag makes all half-bridges Hi-Z and shutdown low
// - power-on clear resets overload latch; supplies good makes block operational
// - any supply undervoltage gives Hi-Z outputs and shutdown output low
// - undervoltage recovery is automatic once all supplies are good
// - reset pin low forces every half-bridge into Hi-Z
// - reset pin low holds the shutdown output released high
// - rising edge on reset pin clears the overload latch and resumes
// - mode low, reset low: bias and all channels Hi-Z
// - mode high, reset low: bias active, all channels Hi-Z
// - mode high, reset high: bias off, channels A to F switching
// - mode low, reset high: bias off, A to C switching, D to F Hi-Z
// - shutdown and warning outputs together encode fault status
// - reset pin low forces both shutdown and warning outputs high
//
// Added by the designer: the placing of the registers and strobed register access.
`include "power_stage_map.vh"
`default_nettype none

module power_stage_fault_and_startup_ctrl #(
    parameter CHANNELS        = 6,
    parameter HALF            = 3,
    parameter OVLD_WIDTH      = 16,
    parameter OVERLOAD_CYCLES = (`OVERLOAD_TIME_NS + `CLK_PERIOD_NS - 1)
                                / `CLK_PERIOD_NS
) (
    input  wire                  clock,
    input  wire                  rstn,
    input  wire                  reset_pin_n,
    input  wire                  mode_select_three,
    input  wire                  overcurrent_trim_pin,
    input  wire [CHANNELS-1:0]   pwm_in,
    input  wire [CHANNELS-1:0]   oc_high_trip,
    input  wire [CHANNELS-1:0]   oc_low_trip,
    input  wire                  temp_warn_flag,
    input  wire                  thermal_shutdown_event,
    input  wire                  gate_drive_supply_ok,
    input  wire                  common_supply_ok,
    input  wire [3:0]            addr,
    input  wire [31:0]           wdata,
    input  wire                  wr,
    input  wire                  rd,
    output reg  [31:0]           rdata,
    output reg  [CHANNELS-1:0]   high_gate,
    output reg  [CHANNELS-1:0]   low_gate,
    output reg  [CHANNELS-1:0]   stage_oe,
    output reg                   bias_precharge_control,
    output wire                  shutdown_fault_n_o,
    output reg                   shutdown_fault_n_oe,
    output wire                  over_temp_warning_n_o,
    output reg                   over_temp_warning_n_oe,
    output reg  [15:0]           oc_limit_sat_ma,
    output reg  [15:0]           oc_limit_sub_ma,
    output wire                  overload_latch,
    output wire                  undervoltage_guard
);

    // one-hot start-up states
    localparam [4:0] ST_OFF   = 5'b0_0001;
    localparam [4:0] ST_BIAS  = 5'b0_0010;
    localparam [4:0] ST_SIX   = 5'b0_0100;
    localparam [4:0] ST_THREE = 5'b0_1000;
    localparam [4:0] ST_FAULT = 5'b1_0000;

    localparam [OVLD_WIDTH-1:0] OVLD_LIMIT = OVERLOAD_CYCLES[OVLD_WIDTH-1:0];
    localparam [OVLD_WIDTH-1:0] OVLD_ONE   = {{(OVLD_WIDTH-1){1'b0}}, 1'b1};

    // synchronised analog flags
    wire [CHANNELS-1:0] oc_high_s;
    wire [CHANNELS-1:0] oc_low_s;
    wire                warn_s;
    wire                therm_s;
    wire                gvdd_ok_s;
    wire                vdd_ok_s;

    flag_sync #(
        .WIDTH (2*CHANNELS+4)
    ) u_sync (
        .clock    (clock),
        .rstn     (rstn),
        .flag_in  ({oc_high_trip, oc_low_trip, temp_warn_flag,
                    thermal_shutdown_event, gate_drive_supply_ok,
                    common_supply_ok}),
        .flag_out ({oc_high_s, oc_low_s, warn_s, therm_s,
                    gvdd_ok_s, vdd_ok_s})
    );

    reg  [4:0]            state_r;
    reg  [4:0]            state_nxt;
    reg                   latch_r;
    reg                   latch_nxt;
    reg  [OVLD_WIDTH-1:0] ovld_cnt_r;
    reg  [OVLD_WIDTH-1:0] ovld_cnt_nxt;
    reg                   reset_pin_d_r;
    reg  [1:0]            ctrl_r;
    reg                   uv_r;

    wire any_oc      = |(oc_high_s | oc_low_s);
    wire supplies_ok = gvdd_ok_s & vdd_ok_s;
    wire reset_rise  = reset_pin_n & ~reset_pin_d_r;
    wire trim_18k    = ctrl_r[`CTRL_TRIM_OVR] ? ctrl_r[`CTRL_TRIM_SEL]
                                              : overcurrent_trim_pin;
    wire fault_now   = latch_r | therm_s | ~supplies_ok;

    assign overload_latch     = latch_r;
    assign undervoltage_guard = uv_r;
    // open-drain pins only ever pull low
    assign shutdown_fault_n_o    = 1'b0;
    assign over_temp_warning_n_o = 1'b0;

    // saturating add used by the persistence counter
    function [OVLD_WIDTH-1:0] sat_inc;
        input [OVLD_WIDTH-1:0] val;
        input [OVLD_WIDTH-1:0] lim;
        begin
            if (val >= lim) begin
                sat_inc = lim;
            end else begin
                sat_inc = val + OVLD_ONE;
            end
        end
    endfunction

    // channel enable mask for a given state
    function [CHANNELS-1:0] chan_mask;
        input [4:0] st;
        begin
            case (st)
                ST_SIX:   chan_mask = {CHANNELS{1'b1}};
                ST_THREE: chan_mask = {{(CHANNELS-HALF){1'b0}},
                                       {HALF{1'b1}}};
                default:  chan_mask = {CHANNELS{1'b0}};
            endcase
        end
    endfunction

    // reset pin history for edge detection
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reset_pin_d_r <= 1'b0;
        end else begin
            reset_pin_d_r <= reset_pin_n;
        end
    end

    // overcurrent persistence counter, clears as soon as trips end
    always @* begin
        if (any_oc && reset_pin_n) begin
            ovld_cnt_nxt = sat_inc(ovld_cnt_r, OVLD_LIMIT);
        end else begin
            ovld_cnt_nxt = {OVLD_WIDTH{1'b0}};
        end
    end

    // overload latch: set beats the release edge in the same cycle
    always @* begin
        latch_nxt = latch_r;
        if (reset_rise) begin
            latch_nxt = 1'b0;
        end
        if (any_oc && reset_pin_n && ovld_cnt_r >= OVLD_LIMIT) begin
            latch_nxt = 1'b1;
        end
    end

    // power-on clear is the asynchronous reset of the latch
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            latch_r    <= 1'b0;
            ovld_cnt_r <= {OVLD_WIDTH{1'b0}};
            uv_r       <= 1'b1;
        end else begin
            latch_r    <= latch_nxt;
            ovld_cnt_r <= ovld_cnt_nxt;
            uv_r       <= ~supplies_ok;
        end
    end

    // start-up sequencing from mode pin and reset pin
    always @* begin
        case ({mode_select_three, reset_pin_n})
            2'b00:   state_nxt = ST_OFF;
            2'b10:   state_nxt = ST_BIAS;
            2'b11:   state_nxt = ST_SIX;
            2'b01:   state_nxt = ST_THREE;
            default: state_nxt = ST_OFF;
        endcase
        // faults only matter once switching is requested
        if (reset_pin_n && fault_now) begin
            state_nxt = ST_FAULT;
        end
        // nothing runs until both supplies are up
        if (!supplies_ok) begin
            state_nxt = reset_pin_n ? ST_FAULT : ST_OFF;
        end
    end

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    // power stage drive; registered so pins never glitch
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            high_gate              <= {CHANNELS{1'b0}};
            low_gate               <= {CHANNELS{1'b0}};
            stage_oe               <= {CHANNELS{1'b0}};
            bias_precharge_control <= 1'b0;
        end else begin
            // reset low and faults both yield an all-zero mask
            stage_oe  <= chan_mask(state_nxt);
            // tripped switch is held off, current cannot keep rising
            high_gate <= chan_mask(state_nxt) & pwm_in
                         & ~oc_high_s;
            low_gate  <= chan_mask(state_nxt) & ~pwm_in
                         & ~oc_low_s;
            bias_precharge_control <= (state_nxt == ST_BIAS);
        end
    end

    // status pins: enable high pulls the pin low
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            shutdown_fault_n_oe    <= 1'b0;
            over_temp_warning_n_oe <= 1'b0;
        end else if (!reset_pin_n) begin
            shutdown_fault_n_oe    <= 1'b0;
            over_temp_warning_n_oe <= 1'b0;
        end else begin
            shutdown_fault_n_oe    <= fault_now;
            over_temp_warning_n_oe <= warn_s | therm_s;
        end
    end

    // trim setting to analog current limit
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            oc_limit_sat_ma <= `LIM_15K_SAT;
            oc_limit_sub_ma <= `LIM_15K_SUB;
        end else if (trim_18k) begin
            oc_limit_sat_ma <= `LIM_18K_SAT;
            oc_limit_sub_ma <= `LIM_18K_SUB;
        end else begin
            oc_limit_sat_ma <= `LIM_15K_SAT;
            oc_limit_sub_ma <= `LIM_15K_SUB;
        end
    end

    // control register write
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= `CTRL_RESET_VAL;
        end else if (wr && addr == `ADDR_CTRL) begin
            ctrl_r <= wdata[`CTRL_TRIM_SEL:`CTRL_TRIM_OVR];
        end
    end

    // read mux; unmapped reads return zero
    reg [31:0] rd_val;
    always @* begin
        rd_val = 32'h0000_0000;
        case (addr)
            `ADDR_CTRL: begin
                rd_val[`CTRL_TRIM_SEL:`CTRL_TRIM_OVR] = ctrl_r;
            end
            `ADDR_STATUS: begin
                rd_val[`ST_LATCH] = latch_r;
                rd_val[`ST_UV]    = uv_r;
                rd_val[`ST_THERM] = therm_s;
                rd_val[`ST_WARN]  = warn_s;
                rd_val[`ST_OC]    = any_oc;
                rd_val[`ST_RESET] = reset_pin_n;
                rd_val[`ST_MODE]  = mode_select_three;
                rd_val[`ST_STATE_MSB:`ST_STATE_LSB] = state_r;
            end
            `ADDR_LIMIT: begin
                rd_val[`LIM_SAT_MSB:`LIM_SAT_LSB] = oc_limit_sat_ma;
                rd_val[`LIM_SUB_MSB:`LIM_SUB_LSB] = oc_limit_sub_ma;
            end
            `ADDR_OVLD: begin
                rd_val[OVLD_WIDTH-1:0] = ovld_cnt_r;
            end
            default: begin
                rd_val = 32'h0000_0000;
            end
        endcase
    end

    // read data stand only in the cycle after the strobe
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdata <= 32'h0000_0000;
        end else if (rd) begin
            rdata <= rd_val;
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

endmodule // power_stage_fault_and_startup_ctrl

`default_nettype wire

// ### verif/pwm_controller_model.sv
// controller-side model: drives reset and mode, reads open-drain status
`default_nettype none
module pwm_controller_model #(
    parameter int RESTART_WAIT = 16
) (
    input  wire logic clock,
    input  wire logic sd_oe,
    input  wire logic sd_o,
    input  wire logic otw_oe,
    input  wire logic otw_o,
    output var  logic reset_pin_n,
    output var  logic mode_select_three,
    output wire logic sd_n,
    output wire logic otw_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reset_pin_n = 1'b0;
        mode_select_three = 1'b0;
    end
    // pull-ups hold both lines high once released
    assign sd_n  = sd_oe ? sd_o : 1'b1;
    assign otw_n = otw_oe ? otw_o : 1'b1;
    task automatic set_pins(input logic m, input logic r);
        @(posedge clock);
        mode_select_three <= m;
        reset_pin_n <= r;
    endtask
    // bias first so the blocking caps charge before switching
    task automatic start(input logic m);
        set_pins(1'b1, 1'b0);
        repeat (8) @(posedge clock);
        set_pins(m, 1'b1);
    endtask
    // wait is scaled far below a second to keep runs short
    task automatic restart(input logic m);
        set_pins(m, 1'b0);
        repeat (RESTART_WAIT) @(posedge clock);
        set_pins(m, 1'b1);
    endtask
endmodule // pwm_controller_model
`default_nettype wire

// ### verif/power_stage_assertions.sv
// assertions on the power stage controller ports
`default_nettype none
module power_stage_checker #(
    parameter CHANNELS = 6
) (
    input wire logic                clock,
    input wire logic                rstn,
    input wire logic                reset_pin_n,
    input wire logic                mode_select_three,
    input wire logic [CHANNELS-1:0] oc_high_trip,
    input wire logic [CHANNELS-1:0] high_gate,
    input wire logic [CHANNELS-1:0] stage_oe,
    input wire logic                bias_precharge_control,
    input wire logic                shutdown_fault_n_oe,
    input wire logic                over_temp_warning_n_oe,
    input wire logic                overload_latch,
    input wire logic                undervoltage_guard
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rstn);
    AST_RESET_HIZ: assert property (!reset_pin_n |=> stage_oe == '0)
        else $error("outputs driving while reset low");
    AST_RESET_FLAGS: assert property (!reset_pin_n |=>
        !shutdown_fault_n_oe && !over_temp_warning_n_oe)
        else $error("status pin pulled low while reset low");
    AST_BIAS_ON: assert property (mode_select_three && !reset_pin_n
        |=> bias_precharge_control || undervoltage_guard)
        else $error("bias not active");
    AST_BIAS_OFF: assert property ((reset_pin_n || !mode_select_three)
        |=> !bias_precharge_control) else $error("bias active");
    AST_THREE_HIZ: assert property (!mode_select_three
        |=> stage_oe[CHANNELS-1:3] == '0) else $error("upper channels on");
    AST_FAULT_HIZ: assert property (shutdown_fault_n_oe
        |-> stage_oe == '0) else $error("driving during shutdown");
    AST_UV_FLAG: assert property (undervoltage_guard && reset_pin_n
        |-> ##[0:2] (shutdown_fault_n_oe || !reset_pin_n))
        else $error("undervoltage not signalled");
    AST_LATCH_CLR: assert property ($rose(reset_pin_n)
        |-> ##[1:2] !overload_latch) else $error("latch not cleared");
    AST_LATCH_HOLD: assert property (overload_latch && reset_pin_n
        && $past(reset_pin_n) && $past(reset_pin_n, 2) |=> overload_latch)
        else $error("latch dropped without reset edge");
    AST_CURRENT_LIMIT: assert property (oc_high_trip[0] [*5]
        |-> !high_gate[0]) else $error("tripped switch still driven");
endmodule // power_stage_checker
bind power_stage_fault_and_startup_ctrl power_stage_checker #(
    .CHANNELS(CHANNELS)) chk_inst (.clock, .rstn, .reset_pin_n,
    .mode_select_three, .oc_high_trip, .high_gate, .stage_oe,
    .bias_precharge_control, .shutdown_fault_n_oe, .over_temp_warning_n_oe,
    .overload_latch, .undervoltage_guard);
`default_nettype wire

// ### verif/test_power_stage_fault_and_startup_ctrl.sv
// self-checking bench for the power stage controller
`default_nettype none
module test_power_stage_fault_and_startup_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, rstn = 0, trim = 0, warn = 0, therm = 0;
    logic gd_ok = 1, cm_ok = 1, wr = 0, rd = 0;
    logic [5:0] pwm = 0, oc_h = 0, oc_l = 0, oe, hg, lg;
    logic [3:0] addr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [15:0] lim_sat, lim_sub;
    logic rst_n, mode, bias, sd_o, sd_oe, otw_o, otw_oe, sd_n, otw_n;
    logic latch, uvg;
    int n_fail = 0, num_checks = 0, seed = 608;
    always #2 clock = ~clock;
    always @(posedge clock) pwm <= $random(seed);
    power_stage_fault_and_startup_ctrl #(.OVERLOAD_CYCLES(4))
        power_stage_fault_and_startup_ctrl_inst (.clock, .rstn,
        .reset_pin_n(rst_n), .mode_select_three(mode),
        .overcurrent_trim_pin(trim), .pwm_in(pwm), .oc_high_trip(oc_h),
        .oc_low_trip(oc_l), .temp_warn_flag(warn),
        .thermal_shutdown_event(therm), .gate_drive_supply_ok(gd_ok),
        .common_supply_ok(cm_ok), .addr, .wdata, .wr, .rd, .rdata,
        .high_gate(hg), .low_gate(lg), .stage_oe(oe),
        .bias_precharge_control(bias), .shutdown_fault_n_o(sd_o),
        .shutdown_fault_n_oe(sd_oe), .over_temp_warning_n_o(otw_o),
        .over_temp_warning_n_oe(otw_oe), .oc_limit_sat_ma(lim_sat),
        .oc_limit_sub_ma(lim_sub), .overload_latch(latch),
        .undervoltage_guard(uvg));
    pwm_controller_model pwm_controller_model_inst (.clock, .sd_oe, .sd_o,
        .otw_oe, .otw_o, .reset_pin_n(rst_n), .mode_select_three(mode),
        .sd_n, .otw_n);
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // reference: enables from mode, reset and any shutdown cause
    function automatic logic [5:0] exp_oe(int m, int r, int flt);
        if (!r || flt)
            return 6'h00;
        return m ? 6'h3F : 6'h07;
    endfunction
    task automatic settle;
        repeat (6) @(posedge clock);
        #1;
    endtask
    task automatic flags(input logic w, t, g, c);
        @(posedge clock);
        {warn, therm, gd_ok, cm_ok} <= {w, t, g, c};
        settle;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge clock);
        addr <= a;
        wdata <= v;
        wr <= 1;
        @(posedge clock);
        wr <= 0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
        @(posedge clock);
        addr <= a;
        rd <= 1;
        @(posedge clock);
        rd <= 0;
        #1 v = rdata;
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #40000;
        n_fail++;
        final_report;
    end
    initial begin
        repeat (8) @(posedge clock);
        rstn <= 1;
        settle;
        check({lim_sub, lim_sat}, 32'h1F40_1388);
        check(latch, 0);
        for (int i = 0; i < 4; i++) begin
            pwm_controller_model_inst.set_pins(i[1], i[0]);
            settle;
            check(oe, exp_oe(i[1], i[0], 0));
            check(bias, i == 2);
        end
        trim <= 1;
        settle;
        check({lim_sub, lim_sat}, 32'h1D4C_1194);
        trim <= 0;
        wr_reg(4'h0, 32'h0000_0003);
        rd_reg(4'h8, d);
        check(d, 32'h1D4C_1194);
        rd_reg(4'h2, d);
        check(d, 32'h0000_0000);
        wr_reg(4'h0, 32'h0000_0000);
        pwm_controller_model_inst.start(1'b1);
        settle;
        check({sd_n, otw_n, oe}, {2'b11, exp_oe(1, 1, 0)});
        flags(1, 0, 1, 1);
        check({sd_n, otw_n, oe}, {2'b10, 6'h3F});
        flags(1, 1, 1, 1);
        check({sd_n, otw_n, oe}, {2'b00, 6'h00});
        pwm_controller_model_inst.set_pins(1, 0);
        settle;
        check({sd_n, otw_n, oe}, {2'b11, 6'h00});
        check({hg, lg}, 12'h000);
        flags(0, 0, 0, 1);
        check(uvg, 1);
        pwm_controller_model_inst.set_pins(1, 1);
        settle;
        check({sd_n, otw_n, oe}, {2'b01, 6'h00});
        flags(0, 0, 1, 0);
        check({sd_n, otw_n, oe}, {2'b01, 6'h00});
        flags(0, 0, 1, 1);
        check({sd_n, otw_n, oe}, {2'b11, 6'h3F});
        check(uvg, 0);
        @(posedge clock);
        oc_h <= 6'h01;
        oc_l <= $random(seed) | 1;
        repeat (12) @(posedge clock);
        oc_h <= 0;
        oc_l <= 0;
        settle;
        check({latch, sd_n, otw_n, oe}, {3'b101, 6'h00});
        rd_reg(4'h4, d);
        check(d & 32'h0000_0001, 32'h0000_0001);
        pwm_controller_model_inst.restart(1'b1);
        settle;
        check({latch, sd_n, otw_n, oe}, {3'b011, 6'h3F});
        final_report;
    end
endmodule // test_power_stage_fault_and_startup_ctrl
`default_nettype wire
